// ### rtl/frx_exec.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module frx_exec
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Instruction from decode, one per cycle while valid
   input wire logic instr_valid,
   input wire frx_pkg::frx_instr_t instr,
   input wire logic [7:0] file_rdata,
   input wire logic alias_hit,
   // File register write port
   output frx_pkg::frx_fwrite_t file_wr,
   output logic [15:0] indirect_addr,
   // Device reset request
   output logic soft_reset_req,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Timing at a glance:
   //  an instruction is taken at the rising edge where instr_valid is high;
   //  file_wr and soft_reset_req follow one cycle later and stand one cycle;
   //  working, zero, pointer and option values show from the next cycle;
   //  the bus answers without wait states, read data is captured in setup.
   // Hazards and limits:
   //  file_rdata must be settled within the execute cycle, it is not latched;
   //  a bus write to a pointer that an instruction steps in the same cycle
   //  is lost, since the instruction update is the last assignment;
   //  a bus write to working loses likewise against a working instruction;
   //  direct file addresses are 7 bits wide, only pointer-based addresses reach 16;
   //  the relative form never moves the pointer, so loops must step it
   //  with the pre or post forms or over the bus.

   logic [7:0] working_r;
   logic zero_r;
   logic [15:0] pointer_r [0:1];
   logic [7:0] option_r;
   logic reset_flag_n_r = frx_pkg::FRX_RI_FLAG_INIT;
   logic apb_wr;
   logic [7:0] alu_res;
   logic [15:0] ptr_cur;
   logic [15:0] ptr_nxt;
   logic [15:0] eff_addr;
   logic exec;
   logic op_to_working;
   logic op_clear_working;
   logic op_option;
   logic op_soft_reset;
   logic op_ind_store;
   logic op_ind_rel;
   logic [15:0] file_target;
   logic [15:0] rel_offset;
   logic apb_rd_setup;
   logic apb_mapped;

   // Increment or decrement with natural 16-bit wrap
   function automatic logic [15:0] frx_step(input logic [15:0] p, input logic dec);
      frx_step = dec ? p - 16'h0001 : p + 16'h0001;
   endfunction : frx_step

   // Sign extension of the six-bit relative offset to pointer width
   function automatic logic [15:0] frx_sext(input logic [5:0] k);
      frx_sext = {{10{k[5]}}, k};
   endfunction : frx_sext

   // Alias addresses hold nothing; their accesses land at the pointer target
   function automatic logic [15:0] frx_redirect(input logic hit, input logic [6:0] f,
      input logic [15:0] p);
      frx_redirect = hit ? p : {9'h000, f};
   endfunction : frx_redirect

   // True for every offset that answers without an error
   function automatic logic frx_mapped(input logic [11:0] a);
      case (a)
         frx_pkg::FRX_ADDR_WORKING, frx_pkg::FRX_ADDR_STATUS,
         frx_pkg::FRX_ADDR_POINTER0, frx_pkg::FRX_ADDR_POINTER1,
         frx_pkg::FRX_ADDR_OPTION, frx_pkg::FRX_ADDR_POWER:
            frx_mapped = 1'b1;
         default: frx_mapped = 1'b0;
      endcase
   endfunction : frx_mapped

   assign exec = instr_valid;
   assign apb_wr = psel && penable && pwrite;
   assign ptr_cur = pointer_r[instr.ptr_sel];

   // Shared decode of addresses and operands
   assign file_target = frx_redirect(alias_hit, instr.file_addr, ptr_cur);
   assign rel_offset = frx_sext(instr.offset);
   assign apb_rd_setup = psel && !penable && !pwrite;
   assign apb_mapped = frx_mapped(paddr);

   // Decoded strobes, each qualified by a valid instruction
   assign op_to_working = exec && !instr.dest_file &&
      (instr.op == frx_pkg::FRX_OP_COMPLEMENT || instr.op == frx_pkg::FRX_OP_DECREMENT);
   assign op_clear_working = exec && instr.op == frx_pkg::FRX_OP_CLEAR_WORKING;
   assign op_option = exec && instr.op == frx_pkg::FRX_OP_OPTION_LOAD;
   assign op_soft_reset = exec && instr.op == frx_pkg::FRX_OP_SOFT_RESET;
   assign op_ind_store = exec && instr.op == frx_pkg::FRX_OP_INDIRECT_STORE;
   assign op_ind_rel = exec && instr.op == frx_pkg::FRX_OP_INDIRECT_REL;

   // Arithmetic result for complement and decrement
   always_comb
   begin
      case (instr.op)
         frx_pkg::FRX_OP_COMPLEMENT: alu_res = ~file_rdata;
         frx_pkg::FRX_OP_DECREMENT: alu_res = file_rdata - 8'h01;
         default: alu_res = file_rdata;
      endcase
   end

   // Pointer update and effective address of indirect store
   always_comb
   begin
      ptr_nxt = ptr_cur;
      eff_addr = ptr_cur;
      if (instr.op == frx_pkg::FRX_OP_INDIRECT_STORE)
      begin
         ptr_nxt = frx_step(ptr_cur, instr.mode[0]);
         // Pre modes use the updated value, post modes the old one
         eff_addr = instr.mode[1] ? ptr_cur : ptr_nxt;
      end
      else if (instr.op == frx_pkg::FRX_OP_INDIRECT_REL)
      begin
         // Sign-extended offset; pointer left alone
         eff_addr = ptr_cur + rel_offset;
      end
   end

   // Address seen when an alias is touched: the pointer target
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         indirect_addr <= frx_pkg::FRX_POINTER_RST;
      end
      else if (op_ind_rel)
      begin
         // Relative form shows the offset address for this one cycle
         indirect_addr <= eff_addr;
      end
      else
      begin
         indirect_addr <= ptr_cur;
      end
   end

   // File write port, registered
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         file_wr <= '0;
      else
      begin
         file_wr <= '0;
         if (exec)
         begin
            case (instr.op)
               frx_pkg::FRX_OP_COMPLEMENT, frx_pkg::FRX_OP_DECREMENT:
               begin
                  file_wr.en <= instr.dest_file;
                  file_wr.addr <= file_target;
                  file_wr.data <= alu_res;
               end
               frx_pkg::FRX_OP_CLEAR_FILE:
               begin
                  file_wr.en <= 1'b1;
                  file_wr.addr <= file_target;
                  file_wr.data <= frx_pkg::FRX_CLEAR_VALUE;
               end
               frx_pkg::FRX_OP_INDIRECT_STORE, frx_pkg::FRX_OP_INDIRECT_REL:
               begin
                  file_wr.en <= 1'b1;
                  file_wr.addr <= eff_addr;
                  file_wr.data <= working_r;
               end
               default: file_wr <= '0;
            endcase
         end
      end
   end

   // Working register; software may preload it over APB, instructions win
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         working_r <= frx_pkg::FRX_WORKING_RST;
      end
      else if (op_to_working)
      begin
         working_r <= alu_res;
      end
      else if (op_clear_working)
      begin
         working_r <= frx_pkg::FRX_CLEAR_VALUE;
      end
      else if (apb_wr && paddr == frx_pkg::FRX_ADDR_WORKING)
      begin
         working_r <= pwdata[7:0];
      end
   end

   // Zero flag; indirect, option and nop leave it untouched
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         zero_r <= 1'b0;
      else if (exec)
      begin
         case (instr.op)
            frx_pkg::FRX_OP_COMPLEMENT, frx_pkg::FRX_OP_DECREMENT:
               zero_r <= (alu_res == 8'h00);
            frx_pkg::FRX_OP_CLEAR_FILE: zero_r <= 1'b1;
            frx_pkg::FRX_OP_CLEAR_WORKING: zero_r <= 1'b1;
            default: zero_r <= zero_r;
         endcase
      end
   end

   // Pointer registers: instruction updates win over bus writes
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pointer_r[0] <= frx_pkg::FRX_POINTER_RST;
         pointer_r[1] <= frx_pkg::FRX_POINTER_RST;
      end
      else
      begin
         if (apb_wr && paddr == frx_pkg::FRX_ADDR_POINTER0)
         begin
            pointer_r[0] <= pwdata[15:0];
         end
         if (apb_wr && paddr == frx_pkg::FRX_ADDR_POINTER1)
         begin
            pointer_r[1] <= pwdata[15:0];
         end
         // Last assignment wins, so a bus write to the stepped pointer in the same cycle is lost
         if (op_ind_store)
         begin
            pointer_r[instr.ptr_sel] <= ptr_nxt;
         end
      end
   end

   // Option register; a copy of working, status flags not involved
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         option_r <= frx_pkg::FRX_OPTION_RST;
      end
      else if (op_option)
      begin
         option_r <= working_r;
      end
   end

   // Reset request pulse, one cycle after the instruction; the device
   // reset logic outside this block turns it into a full reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         soft_reset_req <= 1'b0;
      end
      else
      begin
         soft_reset_req <= op_soft_reset;
      end
   end

   // Reset-instruction flag, active low. It has no rst_n branch on purpose:
   // the device reset that a software reset causes must not erase the mark.
   // It starts at its power-up value; software writes 1 to re-arm it.
   always_ff @(posedge clk)
   begin
      if (op_soft_reset)
      begin
         reset_flag_n_r <= 1'b0;
      end
      else if (apb_wr && paddr == frx_pkg::FRX_ADDR_POWER && pwdata[0])
      begin
         reset_flag_n_r <= 1'b1;
      end
   end

   // APB read path; zero-wait answers
   assign pready = 1'b1;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (apb_rd_setup)
      begin
         case (paddr)
            frx_pkg::FRX_ADDR_WORKING: prdata <= {24'h00_0000, working_r};
            frx_pkg::FRX_ADDR_STATUS: prdata <= {31'h0000_0000, zero_r};
            frx_pkg::FRX_ADDR_POINTER0: prdata <= {16'h0000, pointer_r[0]};
            frx_pkg::FRX_ADDR_POINTER1: prdata <= {16'h0000, pointer_r[1]};
            frx_pkg::FRX_ADDR_OPTION: prdata <= {24'h00_0000, option_r};
            frx_pkg::FRX_ADDR_POWER: prdata <= {31'h0000_0000, reset_flag_n_r};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Unmapped addresses answer with an error in the access phase only
   always_comb
   begin
      pslverr = 1'b0;
      if (psel && penable && !apb_mapped)
      begin
         pslverr = 1'b1;
      end
   end

endmodule : frx_exec
`default_nettype wire

// ### rtl/frx_pkg.sv
package frx_pkg;

   // Operation codes presented by the decoder
   typedef enum logic [3:0] {
      FRX_OP_NOP,
      FRX_OP_COMPLEMENT,
      FRX_OP_CLEAR_FILE,
      FRX_OP_DECREMENT,
      FRX_OP_CLEAR_WORKING,
      FRX_OP_INDIRECT_STORE,
      FRX_OP_INDIRECT_REL,
      FRX_OP_OPTION_LOAD,
      FRX_OP_SOFT_RESET
   } frx_op_t;

   // Pointer update modes for the indirect store
   localparam logic [1:0] FRX_MODE_PRE_INC = 2'h0;
   localparam logic [1:0] FRX_MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] FRX_MODE_POST_INC = 2'h2;
   localparam logic [1:0] FRX_MODE_POST_DEC = 2'h3;

   // Reset values
   localparam logic [7:0] FRX_WORKING_RST = 8'h00;
   localparam logic [7:0] FRX_OPTION_RST = 8'hFF;
   localparam logic [15:0] FRX_POINTER_RST = 16'h0000;
   localparam logic [7:0] FRX_CLEAR_VALUE = 8'h00;
   localparam logic FRX_RI_FLAG_INIT = 1'b1;

   // Register offsets (byte addresses on APB)
   localparam logic [11:0] FRX_ADDR_CTRL = 12'h000;
   localparam logic [11:0] FRX_ADDR_WORKING = 12'h004;
   localparam logic [11:0] FRX_ADDR_STATUS = 12'h008;
   localparam logic [11:0] FRX_ADDR_POINTER0 = 12'h00C;
   localparam logic [11:0] FRX_ADDR_POINTER1 = 12'h010;
   localparam logic [11:0] FRX_ADDR_OPTION = 12'h014;
   localparam logic [11:0] FRX_ADDR_POWER = 12'h018;

   // Field positions
   localparam int FRX_STAT_ZERO_BIT = 0;
   localparam int FRX_POWER_RI_BIT = 0;

   // Instruction request from decode
   typedef struct packed {
      frx_op_t op;
      logic [6:0] file_addr;
      logic dest_file;
      logic ptr_sel;
      logic [1:0] mode;
      logic [5:0] offset;
   } frx_instr_t;

   // Write request to the file register array
   typedef struct packed {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } frx_fwrite_t;

endpackage : frx_pkg

// ### tb/frx_exec_sva.sv
`timescale 1ns/100ps
`default_nettype none
module frx_exec_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Decode side
   input wire logic instr_valid,
   input wire frx_pkg::frx_instr_t instr,
   input wire logic [7:0] file_rdata,
   // Results
   input wire frx_pkg::frx_fwrite_t file_wr,
   input wire logic soft_reset_req
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Decoded strobes keep the properties short
   wire logic cmp = instr_valid && instr.op == frx_pkg::FRX_OP_COMPLEMENT;
   wire logic dec = instr_valid && instr.op == frx_pkg::FRX_OP_DECREMENT;
   wire logic clr = instr_valid && instr.op == frx_pkg::FRX_OP_CLEAR_FILE;
   wire logic nop = instr_valid && instr.op == frx_pkg::FRX_OP_NOP;
   wire logic srs = instr_valid && instr.op == frx_pkg::FRX_OP_SOFT_RESET;
   wire logic wop = instr_valid && (instr.op == frx_pkg::FRX_OP_OPTION_LOAD ||
      instr.op == frx_pkg::FRX_OP_CLEAR_WORKING);
   cmp_back_a: assert property (cmp && instr.dest_file |=>
      file_wr.en && file_wr.data == ~$past(file_rdata)) else $error("complement write bad");
   cmp_work_a: assert property (cmp && !instr.dest_file |=> !file_wr.en)
      else $error("complement to working wrote file");
   dec_back_a: assert property (dec && instr.dest_file |=>
      file_wr.en && file_wr.data == $past(file_rdata) - 8'h01) else $error("decrement bad");
   clr_file_a: assert property (clr |=> file_wr.en && file_wr.data == 8'h00)
      else $error("clear file bad");
   nop_quiet_a: assert property (nop |=> !file_wr.en && !soft_reset_req)
      else $error("no-op had an effect");
   reset_pulse_a: assert property (srs |=> soft_reset_req)
      else $error("reset request missing");
   reset_cause_a: assert property (soft_reset_req |-> $past(srs))
      else $error("reset request without cause");
   work_only_a: assert property (wop |=> !file_wr.en)
      else $error("working op wrote file");
endmodule : frx_exec_sva
`default_nettype wire

// ### tb/frx_file_model.sv
`timescale 1ns/100ps
`default_nettype none
module frx_file_model (
   // Core side
   input wire logic clk,
   input wire logic [6:0] file_addr,
   input wire frx_pkg::frx_fwrite_t file_wr,
   output logic [7:0] file_rdata
);
   logic [7:0] mem [0:255];
   // Combinational read; writes keep only the low address byte, a small array
   assign file_rdata = mem[file_addr];
   always @(posedge clk)
      if (file_wr.en)
         mem[file_wr.addr[7:0]] <= file_wr.data;
endmodule : frx_file_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk, rst_n, instr_valid, alias_hit, psel, penable, pwrite, pready, pslverr;
   logic soft_reset_req, ps, se, sr;
   logic [1:0] md;
   logic [5:0] ofs;
   logic [6:0] fa;
   logic [7:0] file_rdata, v, w, e;
   logic [11:0] paddr;
   logic [15:0] indirect_addr, seed, p, np, ia;
   logic [31:0] pwdata, prdata, rd;
   int errors, n_checks;
   frx_pkg::frx_op_t op;
   frx_pkg::frx_instr_t instr;
   frx_pkg::frx_fwrite_t file_wr, wr;
   // Block and far-side file array
   frx_exec frx_exec_inst (.clk, .rst_n, .instr_valid, .instr, .file_rdata, .alias_hit,
      .file_wr, .indirect_addr, .soft_reset_req, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   frx_file_model frx_file_model_inst (.clk, .file_addr(instr.file_addr), .file_wr, .file_rdata);
   // Expectation helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [7:0] alu(input frx_pkg::frx_op_t o, input logic [7:0] f);
      return (o == frx_pkg::FRX_OP_DECREMENT) ? f - 8'h01 : ~f;
   endfunction : alu
   // Compare, verdict, bus and instruction tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t %h %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test();
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic apb(input logic wen, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wen;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rdchk
   task automatic exec(input frx_pkg::frx_op_t o, input logic d);
      @(posedge clk);
      instr <= '{o, fa, d, ps, md, ofs};
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      // Results stand one cycle; take them mid-cycle, then realign to an edge
      @(negedge clk);
      wr = file_wr;
      sr = soft_reset_req;
      ia = indirect_addr;
      @(posedge clk);
   endtask : exec
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Watchdog well beyond the five hundred or so cycles needed
   initial
   begin
      #200000;
      errors++;
      stop_test();
   end
   initial
   begin
      rst_n = 1'b0;
      {instr_valid, alias_hit, psel, penable, pwrite, ps, md, ofs, fa, w} = '0;
      {instr, paddr, pwdata} = '0;
      seed = 16'hAE1A;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(frx_pkg::FRX_ADDR_OPTION, 32'h0000_00FF);
      // Random operands with 00, 01 and FF first
      for (int i = 0; i < 40; i++)
      begin
         seed = lfsr(seed);
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : seed[15:8];
         op = seed[0] ? frx_pkg::FRX_OP_DECREMENT : frx_pkg::FRX_OP_COMPLEMENT;
         fa = seed[7:1];
         frx_file_model_inst.mem[fa] = v;
         e = alu(op, v);
         exec(op, seed[2]);
         w = seed[2] ? w : e;
         chk(32'({wr.en, wr.data & {8{seed[2]}}}), 32'({seed[2], e & {8{seed[2]}}}));
         rdchk(frx_pkg::FRX_ADDR_WORKING, 32'(w));
         rdchk(frx_pkg::FRX_ADDR_STATUS, 32'(e == 8'h00));
      end
      // Working value A5 feeds option load, then clears and a no-op
      frx_file_model_inst.mem[fa] = 8'h5A;
      exec(frx_pkg::FRX_OP_COMPLEMENT, 1'b0);
      exec(frx_pkg::FRX_OP_OPTION_LOAD, 1'b0);
      rdchk(frx_pkg::FRX_ADDR_OPTION, 32'h0000_00A5);
      exec(frx_pkg::FRX_OP_CLEAR_WORKING, 1'b0);
      rdchk(frx_pkg::FRX_ADDR_STATUS, 32'h0000_0001);
      rdchk(frx_pkg::FRX_ADDR_WORKING, 32'h0000_0000);
      exec(frx_pkg::FRX_OP_COMPLEMENT, 1'b0);
      exec(frx_pkg::FRX_OP_CLEAR_FILE, 1'b0);
      chk(32'({wr.en, wr.data}), 32'h0000_0100);
      exec(frx_pkg::FRX_OP_NOP, 1'b1);
      chk(32'(wr.en), 32'h0000_0000);
      rdchk(frx_pkg::FRX_ADDR_STATUS, 32'h0000_0001);
      // Each pointer mode from the wrap boundary
      for (int m = 0; m < 4; m++)
      begin
         p = m[0] ? 16'h0000 : 16'hFFFF;
         np = m[0] ? p - 16'h0001 : p + 16'h0001;
         md = m[1:0];
         apb(1'b1, frx_pkg::FRX_ADDR_POINTER0, 32'(p));
         exec(frx_pkg::FRX_OP_INDIRECT_STORE, 1'b0);
         chk(32'({wr.en, wr.addr, wr.data}), 32'({1'b1, m[1] ? p : np, 8'hA5}));
         rdchk(frx_pkg::FRX_ADDR_POINTER0, 32'(np));
         rdchk(frx_pkg::FRX_ADDR_STATUS, 32'h0000_0001);
         chk(32'(indirect_addr), 32'(np));
      end
      // Most negative offset, then an alias access through the same pointer
      {ps, ofs, p} = {1'b1, 6'h20, seed};
      apb(1'b1, frx_pkg::FRX_ADDR_POINTER1, 32'(p));
      exec(frx_pkg::FRX_OP_INDIRECT_REL, 1'b0);
      chk(32'({wr.en, wr.addr}), 32'({1'b1, p - 16'h0020}));
      chk(32'(ia), 32'(p - 16'h0020));
      rdchk(frx_pkg::FRX_ADDR_POINTER1, 32'(p));
      alias_hit <= 1'b1;
      exec(frx_pkg::FRX_OP_CLEAR_FILE, 1'b1);
      alias_hit <= 1'b0;
      chk(32'(wr.addr), 32'(p));
      // Rearm the flag so the software reset has something to mark
      apb(1'b1, frx_pkg::FRX_ADDR_POWER, 32'h0000_0001);
      exec(frx_pkg::FRX_OP_SOFT_RESET, 1'b0);
      chk(32'(sr), 32'h0000_0001);
      rdchk(frx_pkg::FRX_ADDR_POWER, 32'h0000_0000);
      // Device reset that the request causes: the flag survives, option returns
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(frx_pkg::FRX_ADDR_POWER, 32'h0000_0000);
      rdchk(frx_pkg::FRX_ADDR_OPTION, 32'h0000_00FF);
      apb(1'b0, 12'h01C, 32'h0000_0000);
      chk(32'(se), 32'h0000_0001);
      stop_test();
   end
endmodule : tb_top
bind frx_exec frx_exec_sva frx_exec_sva_inst (.clk, .rst_n, .instr_valid, .instr, .file_rdata,
   .file_wr, .soft_reset_req);
`default_nettype wire
